// ---- hw/sar_adc_pkg.sv ----
package sar_adc_pkg;
  // register byte addresses on the cpu bus
  localparam logic [15:0] RES_A_HIGH_ADDR = 16'hFFE0;
  localparam logic [15:0] RES_A_LOW_ADDR = 16'hFFE1;
  localparam logic [15:0] RES_B_HIGH_ADDR = 16'hFFE2;
  localparam logic [15:0] RES_B_LOW_ADDR = 16'hFFE3;
  localparam logic [15:0] RES_C_HIGH_ADDR = 16'hFFE4;
  localparam logic [15:0] RES_C_LOW_ADDR = 16'hFFE5;
  localparam logic [15:0] RES_D_HIGH_ADDR = 16'hFFE6;
  localparam logic [15:0] RES_D_LOW_ADDR = 16'hFFE7;
  localparam logic [15:0] CSR_ADDR = 16'hFFE8;
  localparam logic [15:0] TRIG_ADDR = 16'hFFE9;
  // reset values and fixed read patterns
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] TRIG_RSVD = 8'h7F;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam int RES_BITS = 10;
  localparam int PAD_BITS = 6;
  // conversion timing in clock states
  localparam int SLOW_STATES = 266;
  localparam int FAST_STATES = 134;
  localparam int SLOW_STEP = 24;
  localparam int FAST_STEP = 12;
  localparam int SLOW_SAMPLE = SLOW_STATES - RES_BITS * SLOW_STEP;
  localparam int FAST_SAMPLE = FAST_STATES - RES_BITS * FAST_STEP;
  localparam int CNT_W = 9;
  localparam logic [RES_BITS-1:0] SAR_MSB = 10'h200;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } bus_req_s;

  // control/status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic conv_end_flag;
    logic irq_enable;
    logic conv_start_bit;
    logic scan;
    logic conv_time_select;
    logic [2:0] ch;
  } csr_s;

  typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_TRIAL} conv_state_e;
endpackage

// ---- hw/sar_adc_ctrl.sv ----
`timescale 1ns/1ps
// Function
// - result msbs high byte, two lsbs low top
// - six unused low bits read zero
// - input n of either group to register n
// - results cleared on reset and standby
// - high byte direct, low byte through latch
// - flag cleared by zero write after a read of it set
// - inputs 0-3 group 0, 4-7 group 1
// - single one-shot mode and continuous scan mode
// - trigger pin starts conversion besides software
// - conversion end can raise interrupt
// - converter can be halted on its own
// - fast mode conversion 7.44 us at 18 MHz
// - four 16-bit read-only result registers
// - start bit auto-clears single, scan runs on
// - 266 or 134 states by time select
// - falling trigger edge starts when enabled
module sar_adc_ctrl #(
  parameter int SLOW_STEP_CYC = sar_adc_pkg::SLOW_STEP,
  parameter int FAST_STEP_CYC = sar_adc_pkg::FAST_STEP
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire sar_adc_pkg::bus_req_s BUS_REQ,
  input wire logic STANDBY,
  input wire logic MODULE_STOP,
  input wire logic EXT_TRIG_PIN,
  input wire logic CMP_HIGH,
  output logic [7:0] BUS_RDATA,
  output logic CONV_END_IRQ,
  output logic [9:0] DAC_CODE,
  output logic [2:0] CHANNEL_SEL,
  output logic SAMPLE_HOLD
);
  import sar_adc_pkg::*;

  localparam int SLOW_SAMPLE_CYC = SLOW_STATES - RES_BITS * SLOW_STEP_CYC;
  localparam int FAST_SAMPLE_CYC = FAST_STATES - RES_BITS * FAST_STEP_CYC;
  localparam int SLOW_LAST = SLOW_STATES - 1;
  localparam int FAST_LAST = FAST_STATES - 1;

  // the comparator needs two sync stages plus a settle cycle inside each step
  if (SLOW_STEP_CYC < 4 || FAST_STEP_CYC < 4 || SLOW_SAMPLE_CYC < 1 || FAST_SAMPLE_CYC < 1) begin
    $error("step lengths do not fit the conversion time");
  end

  csr_s csr;
  logic trig_enable;
  logic [15:0] result [4];
  logic [7:0] temp;
  logic flag_armed;
  conv_state_e state;
  logic [CNT_W-1:0] cnt;
  logic [3:0] bit_idx;
  logic [RES_BITS-1:0] sar;
  logic [2:0] ch_cur;
  logic trig_s1, trig_s2, trig_prev;
  logic cmp_s1, cmp_s2;
  logic [CNT_W-1:0] conv_len;

  // bus decode
  wire clr = STANDBY | MODULE_STOP;
  wire res_hit = BUS_REQ.addr >= RES_A_HIGH_ADDR && BUS_REQ.addr <= RES_D_LOW_ADDR;
  wire [1:0] res_idx = BUS_REQ.addr[2:1];
  wire hi_rd = BUS_REQ.rd && res_hit && !BUS_REQ.addr[0];
  wire lo_rd = BUS_REQ.rd && res_hit && BUS_REQ.addr[0];
  wire csr_rd = BUS_REQ.rd && BUS_REQ.addr == CSR_ADDR;
  wire trig_rd = BUS_REQ.rd && BUS_REQ.addr == TRIG_ADDR;
  wire csr_wr = BUS_REQ.wr && BUS_REQ.addr == CSR_ADDR;
  wire trig_wr = BUS_REQ.wr && BUS_REQ.addr == TRIG_ADDR;
  wire [7:0] res_hi = result[res_idx][15:8];
  wire [7:0] rd_mux = hi_rd ? res_hi :
                      lo_rd ? temp :
                      csr_rd ? csr :
                      trig_rd ? {trig_enable, TRIG_RSVD[6:0]} : UNMAPPED_DATA;

  // converter sequencing
  wire [CNT_W-1:0] step_len = csr.conv_time_select ? CNT_W'(FAST_STEP_CYC) : CNT_W'(SLOW_STEP_CYC);
  wire [CNT_W-1:0] sample_len =
    csr.conv_time_select ? CNT_W'(FAST_SAMPLE_CYC) : CNT_W'(SLOW_SAMPLE_CYC);
  wire step_end = cnt == CNT_W'(1);
  wire [RES_BITS-1:0] bit_mask = SAR_MSB >> (4'(RES_BITS - 1) - bit_idx);
  wire [RES_BITS-1:0] sar_keep = cmp_s2 ? sar : (sar & ~bit_mask);
  wire conv_done = state == CONV_TRIAL && step_end && bit_idx == 4'h0 && csr.conv_start_bit;
  wire last_ch = ch_cur[1:0] == csr.ch[1:0];
  wire pass_done = conv_done && (!csr.scan || last_ch); // flag point
  wire [2:0] first_ch = csr.scan ? {csr.ch[2], 2'b00} : csr.ch;
  wire trig_fall = trig_prev && !trig_s2;
  wire trig_start = trig_fall && trig_enable;
  wire flag_clr = csr_wr && !BUS_REQ.wdata[7] && flag_armed;

  // two-stage sync for pin and comparator; edge detect reads only the second stage
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_prev <= 1'b1;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      trig_s1 <= EXT_TRIG_PIN;
      trig_s2 <= trig_s1;
      trig_prev <= trig_s2;
      cmp_s1 <= CMP_HIGH;
      cmp_s2 <= cmp_s1;
    end
  end

  // read data and low-byte latch; a low read alone returns a stale latch
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      BUS_RDATA <= UNMAPPED_DATA;
      temp <= UNMAPPED_DATA;
    end else begin
      BUS_RDATA <= rd_mux;
      if (hi_rd) begin
        temp <= result[res_idx][7:0];
      end
    end
  end

  // control/status: hardware set of the flag wins over the software clear
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      csr <= CSR_RESET;
      flag_armed <= 1'b0;
    end else if (clr) begin
      csr <= CSR_RESET;
      flag_armed <= 1'b0;
    end else begin
      if (csr_wr) begin
        csr[6:0] <= BUS_REQ.wdata[6:0];
      end
      if (conv_done && !csr.scan) begin
        csr.conv_start_bit <= 1'b0;
      end
      if (trig_start) begin
        csr.conv_start_bit <= 1'b1;
      end
      if (pass_done) begin
        csr.conv_end_flag <= 1'b1;
      end else if (flag_clr) begin
        csr.conv_end_flag <= 1'b0;
      end
      if (csr_rd && csr.conv_end_flag) begin
        flag_armed <= 1'b1;
      end else if (flag_clr || !csr.conv_end_flag) begin
        flag_armed <= 1'b0;
      end
    end
  end

  // trigger enable; reserved bits are constant ones on read
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      trig_enable <= 1'b0;
    end else if (clr) begin
      trig_enable <= 1'b0;
    end else if (trig_wr) begin
      trig_enable <= BUS_REQ.wdata[7];
    end
  end

  // result registers, shared by both groups by low channel bits
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 4; i++) result[i] <= RESULT_RESET;
    end else if (clr) begin
      for (int i = 0; i < 4; i++) result[i] <= RESULT_RESET;
    end else if (conv_done) begin
      result[ch_cur[1:0]] <= {sar_keep, PAD_BITS'(0)};
    end
  end

  // sample phase then one step per result bit, msb first
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= CONV_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      sar <= '0;
      ch_cur <= '0;
    end else if (clr || !csr.conv_start_bit) begin
      state <= CONV_IDLE; // clearing the start bit aborts mid-conversion
      cnt <= '0;
      sar <= '0;
    end else begin
      unique case (state)
        CONV_IDLE: begin
          state <= CONV_SAMPLE;
          cnt <= sample_len;
          ch_cur <= first_ch;
        end
        CONV_SAMPLE: begin
          cnt <= cnt - CNT_W'(1);
          if (step_end) begin
            state <= CONV_TRIAL;
            cnt <= step_len;
            sar <= SAR_MSB;
            bit_idx <= 4'(RES_BITS - 1);
          end
        end
        CONV_TRIAL: begin
          cnt <= cnt - CNT_W'(1);
          if (step_end && bit_idx != 4'h0) begin
            sar <= sar_keep | (bit_mask >> 1);
            bit_idx <= bit_idx - 4'h1;
            cnt <= step_len;
          end else if (step_end) begin
            sar <= sar_keep;
            state <= csr.scan ? CONV_SAMPLE : CONV_IDLE;
            cnt <= sample_len;
            ch_cur <= (csr.scan && !last_ch) ? ch_cur + 3'h1 : first_ch;
          end
        end
      endcase
    end
  end

  // outputs all registered
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      CONV_END_IRQ <= 1'b0;
      DAC_CODE <= '0;
      CHANNEL_SEL <= '0;
      SAMPLE_HOLD <= 1'b0;
    end else begin
      CONV_END_IRQ <= csr.conv_end_flag && csr.irq_enable;
      DAC_CODE <= sar;
      CHANNEL_SEL <= ch_cur;
      SAMPLE_HOLD <= state == CONV_SAMPLE;
    end
  end

  // helper: cycles spent in the current conversion
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      conv_len <= '0;
    end else if (state == CONV_IDLE || conv_done) begin
      conv_len <= '0;
    end else begin
      conv_len <= conv_len + CNT_W'(1);
    end
  end

  sequence seq_done_single;
    conv_done && !csr.scan && !clr;
  endsequence

  sequence seq_scan_advance;
    conv_done && csr.scan && !last_ch && !clr && !csr_wr;
  endsequence

  AST_LOW_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_B)
    lo_rd |=> BUS_RDATA[5:0] == 6'h00)
    else $error("low byte unused bits not zero");

  AST_HIGH_PASS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    hi_rd |=> BUS_RDATA == $past(res_hi) && temp == $past(result[res_idx][7:0]))
    else $error("high read did not pass high byte and latch low byte");

  AST_CLEAR_STANDBY: assert property (@(posedge CLOCK) disable iff (!RST_B)
    clr |=> result[0] == RESULT_RESET && result[3] == RESULT_RESET && csr == CSR_RESET)
    else $error("standby did not clear registers");

  AST_FLAG_NO_WRITE_SET: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !csr.conv_end_flag && !pass_done |=> !csr.conv_end_flag)
    else $error("flag set without conversion end");

  AST_SINGLE_END: assert property (@(posedge CLOCK) disable iff (!RST_B)
    seq_done_single ##0 !trig_start |=>
      !csr.conv_start_bit && csr.conv_end_flag ##1 state == CONV_IDLE)
    else $error("single conversion end handling wrong");

  AST_TRIG_START: assert property (@(posedge CLOCK) disable iff (!RST_B)
    trig_start && !clr && state == CONV_IDLE && !csr.conv_start_bit |=>
      csr.conv_start_bit ##1 (state == CONV_SAMPLE || $past(clr)))
    else $error("trigger falling edge did not start conversion");

  AST_CONV_LENGTH: assert property (@(posedge CLOCK) disable iff (!RST_B)
    conv_done |-> conv_len == (csr.conv_time_select ? CNT_W'(FAST_LAST) : CNT_W'(SLOW_LAST)))
    else $error("conversion length wrong");

  AST_IRQ: assert property (@(posedge CLOCK) disable iff (!RST_B)
    pass_done && csr.irq_enable && !clr && !csr_wr |=> ##1 CONV_END_IRQ)
    else $error("end interrupt not raised");

  AST_SCAN_ORDER: assert property (@(posedge CLOCK) disable iff (!RST_B)
    seq_scan_advance |=> ch_cur == $past(ch_cur) + 3'h1 && state == CONV_SAMPLE)
    else $error("scan did not advance to next input");

  AST_RESULT_STORE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    conv_done && !clr |=> result[$past(ch_cur[1:0])] == {$past(sar_keep), PAD_BITS'(0)})
    else $error("result stored in wrong register or layout");

  AST_FLAG_KEEP_UNREAD: assert property (@(posedge CLOCK) disable iff (!RST_B)
    csr.conv_end_flag && csr_wr && !flag_armed && !clr |=> csr.conv_end_flag)
    else $error("flag cleared without a prior status read");

  AST_TRIG_READ: assert property (@(posedge CLOCK) disable iff (!RST_B)
    trig_rd |=> BUS_RDATA == {$past(trig_enable), TRIG_RSVD[6:0]})
    else $error("trigger register read back wrong");

  AST_RESULT_READONLY: assert property (@(posedge CLOCK) disable iff (!RST_B)
    BUS_REQ.wr && res_hit && !conv_done && !clr |=>
      $stable(result[0]) && $stable(result[1]) && $stable(result[2]) && $stable(result[3]))
    else $error("bus write changed a result register");

  AST_SCAN_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_B)
    conv_done && csr.scan && last_ch && !clr && !csr_wr |=>
      ch_cur == {$past(csr.ch[2]), 2'b00} && state == CONV_SAMPLE)
    else $error("scan did not restart from the group base");

  AST_GROUP_START: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state == CONV_IDLE && csr.conv_start_bit && !clr |=> ch_cur[2] == $past(csr.ch[2]))
    else $error("conversion started outside the selected group");

  AST_START_HELD: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state != CONV_IDLE && !$past(csr_wr) |-> csr.conv_start_bit)
    else $error("start bit low during a conversion");

  AST_ABORT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state != CONV_IDLE && !csr.conv_start_bit |=> state == CONV_IDLE)
    else $error("clearing the start bit did not stop the converter");

  AST_UNMAPPED_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_B)
    BUS_REQ.rd && !res_hit && !csr_rd && !trig_rd |=> BUS_RDATA == UNMAPPED_DATA)
    else $error("unmapped read not zero");

  AST_LOW_LATCH: assert property (@(posedge CLOCK) disable iff (!RST_B)
    lo_rd |=> BUS_RDATA == $past(temp))
    else $error("low read did not return the latch");

  AST_TEMP_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !hi_rd |=> $stable(temp))
    else $error("low-byte latch changed without a high read");

  AST_IRQ_MASK: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !csr.irq_enable |=> !CONV_END_IRQ)
    else $error("end interrupt raised while disabled");
endmodule

// ---- testbench/analog_front_model.sv ----
`timescale 1ns/1ps
// comparator behind the converter: one fixed level per analog input
// the levels are static, so the answer settles before the two sync stages
module analog_front_model (
  input wire logic [7:0][9:0] levels,
  input wire logic [9:0] dac_code,
  input wire logic [2:0] channel_sel,
  output logic cmp_high
);
  // high when the selected input is at or above the trial code
  assign cmp_high = levels[channel_sel] >= dac_code;
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import sar_adc_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  bus_req_s req = '0;
  logic standby = 1'b0;
  logic module_stop = 1'b0;
  logic trig_pin = 1'b1;
  logic cmp_high;
  logic [7:0] rdata;
  logic irq;
  logic [9:0] dac_code;
  logic [2:0] chan;
  logic sample_hold;
  // low bits differ per input so a wrong register or latch shows up
  logic [7:0][9:0] lv = {10'h337, 10'h2DE, 10'h282, 10'h229,
    10'h1CF, 10'h176, 10'h11D, 10'h0C3};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int sh_cyc = 0;
  int irq_cyc = 0;
  int n;
  logic sh_d = 1'b0;
  logic irq_d = 1'b0;
  logic [2:0] chq[$];
  logic [7:0] d;

  always #2 clock = ~clock;

  sar_adc_ctrl sar_adc_ctrl_i (.CLOCK(clock), .RST_B(rst_b), .BUS_REQ(req),
    .STANDBY(standby), .MODULE_STOP(module_stop), .EXT_TRIG_PIN(trig_pin),
    .CMP_HIGH(cmp_high), .BUS_RDATA(rdata), .CONV_END_IRQ(irq),
    .DAC_CODE(dac_code), .CHANNEL_SEL(chan), .SAMPLE_HOLD(sample_hold));
  analog_front_model analog_front_model_i (.levels(lv), .dac_code(dac_code),
    .channel_sel(chan), .cmp_high(cmp_high));

  // stamp sample starts and irq rises, and log the channel order; settled values only
  always @(negedge clock) begin
    cyc <= cyc + 1;
    sh_d <= sample_hold;
    irq_d <= irq;
    if (sample_hold && !sh_d) begin
      sh_cyc <= cyc;
      chq.push_back(chan);
    end
    if (irq && !irq_d) irq_cyc <= cyc;
  end

  task end_sim;
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // bus cycles: request set after a falling edge, answer taken one cycle on
  task rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clock);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clock);
    v = rdata;
    req.rd = 1'b0;
  endtask

  task wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clock);
    req.addr = a;
    req.wdata = v;
    req.wr = 1'b1;
    @(negedge clock);
    req.wr = 1'b0;
  endtask

  task chk_rd(input logic [15:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask

  // high byte first, then low through the latch, as software must
  task chk_res(input int ch);
    logic [15:0] a;
    a = RES_A_HIGH_ADDR + 16'(2 * (ch % 4));
    chk_rd(a, lv[ch][9:2]);
    chk_rd(a + 16'h0001, {lv[ch][1:0], 6'h00});
  endtask

  // polling reads also arm the flag clear
  task wait_flag;
    for (int i = 0; i < 2000; i++) begin
      rd(CSR_ADDR, d);
      if (d[7] === 1'b1) return;
    end
    fails++;
    end_sim();
  endtask

  task wait_irq;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clock);
      if (irq === 1'b1) return;
    end
    fails++;
    end_sim();
  endtask

  task t_reset;
    for (int i = 0; i < 8; i++) chk_rd(RES_A_HIGH_ADDR + 16'(i), 8'h00);
    chk_rd(CSR_ADDR, CSR_RESET);
    chk_rd(TRIG_ADDR, TRIG_RSVD);
    wr(RES_A_HIGH_ADDR, 8'h55);
    chk_rd(RES_A_HIGH_ADDR, 8'h00);
    chk_rd(16'hFFEA, 8'h00);
  endtask

  task t_single;
    wr(CSR_ADDR, 8'h6D);
    wait_irq();
    chk_rd(CSR_ADDR, 8'hCD);
    `CHK((irq_cyc - sh_cyc) inside {[132:137]}, 1'b1)
    chk_res(5);
    wr(CSR_ADDR, 8'hCD);
    chk_rd(CSR_ADDR, 8'hCD);
    wr(CSR_ADDR, 8'h4D);
    chk_rd(CSR_ADDR, 8'h4D);
    `CHK(irq, 1'b0)
  endtask

  task t_scan;
    chq.delete();
    wr(CSR_ADDR, 8'h36);
    wait_flag();
    `CHK(d, 8'hB6)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 3; i++) `CHK(chq[i], 3'(4 + i))
    for (int i = 4; i < 7; i++) chk_res(i);
    chk_rd(RES_D_HIGH_ADDR, 8'h00);
    wr(CSR_ADDR, 8'h06);
    repeat (3) @(negedge clock);
    n = chq.size();
    repeat (600) @(negedge clock);
    `CHK(chq.size(), n)
    chk_rd(CSR_ADDR, 8'h06);
  endtask

  // pin falls while enabled, then again while disabled
  task t_trig;
    wr(TRIG_ADDR, 8'h80);
    chk_rd(TRIG_ADDR, 8'hFF);
    wr(CSR_ADDR, 8'h40);
    chk_rd(CSR_ADDR, 8'h40);
    trig_pin = 1'b0;
    wait_irq();
    trig_pin = 1'b1;
    wr(CSR_ADDR, 8'h40);
    chk_rd(CSR_ADDR, 8'hC0);
    `CHK((irq_cyc - sh_cyc) inside {[264:269]}, 1'b1)
    chk_res(0);
    wr(CSR_ADDR, 8'h40);
    wr(TRIG_ADDR, 8'h00);
    @(negedge clock);
    trig_pin = 1'b0;
    repeat (50) @(negedge clock);
    trig_pin = 1'b1;
    chk_rd(CSR_ADDR, 8'h40);
  endtask

  // the latch keeps the low byte of the last high read
  task t_latch;
    chk_rd(RES_A_HIGH_ADDR, lv[0][9:2]);
    chk_rd(RES_B_LOW_ADDR, {lv[0][1:0], 6'h00});
  endtask

  task t_stop(input logic which, input int ch);
    wr(CSR_ADDR, 8'h28 | 8'(ch));
    wait_flag();
    chk_res(ch);
    wr(TRIG_ADDR, 8'h80);
    standby = !which;
    module_stop = which;
    repeat (2) @(negedge clock);
    standby = 1'b0;
    module_stop = 1'b0;
    chk_rd(CSR_ADDR, 8'h00);
    chk_rd(TRIG_ADDR, TRIG_RSVD);
    chk_rd(RES_A_HIGH_ADDR + 16'(2 * (ch % 4)), 8'h00);
  endtask

  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    t_reset();
    t_single();
    t_scan();
    t_trig();
    t_latch();
    t_stop(1'b0, 7);
    t_stop(1'b1, 2);
    end_sim();
  end
endmodule
